/* foot_pkg.sv */
package foot_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 250;
  localparam int TIME_UNIT_MS = 100;
  localparam int TICK_CYCLES_DEF = TIME_UNIT_MS * 1000 * CLK_MHZ;
  localparam int HALF_MIN_MS = 30000;
  localparam logic [15:0] STEP_UNITS = 16'(HALF_MIN_MS / TIME_UNIT_MS);
  localparam logic [4:0] LIMIT_MAX = 5'h14;
  localparam logic [15:0] ACTUAL_MAX = 16'hFFFF;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_DIAG = 8'h08;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
  localparam int CTRL_FOUR_BIT = 0;
  localparam int CTRL_EXT_BIT = 1;
  localparam int CTRL_LIM_LSB = 8;
  localparam int LIM_W = 5;
  localparam logic CTRL_FOUR_RST = 1'h1;
  localparam logic CTRL_EXT_RST = 1'h0;
  localparam logic [4:0] CTRL_LIM_RST = 5'h00;
  localparam int STAT_EN_BIT = 0;
  localparam int STAT_ERR_BIT = 1;
  localparam int STAT_ACT_LSB = 16;
  localparam int IRQ_GRANT = 0;
  localparam int IRQ_WITHDRAW = 1;
  localparam int IRQ_ERROR = 2;
  localparam int IRQ_PANIC = 3;
  localparam int IRQ_W = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // Contact patterns, bit 0 is channel 1
  // ****************************************
  localparam logic [1:0] PAT2_REL = 2'h1;
  localparam logic [1:0] PAT2_OPER = 2'h3;
  localparam logic [1:0] PAT2_PANIC = 2'h2;
  localparam logic [3:0] PAT4_REL = 4'h5;
  localparam logic [3:0] PAT4_OPER = 4'hF;
  localparam logic [3:0] PAT4_PANIC = 4'hA;

  // ****************************************
  // Diagnostic codes
  // ****************************************
  localparam logic [31:0] DG_NO_ENABLE = 32'h0000_0000;
  localparam logic [31:0] DG_WAIT_ACT = 32'h0000_2001;
  localparam logic [31:0] DG_RELEASED = 32'h0000_2011;
  localparam logic [31:0] DG_PANIC = 32'h0000_2013;
  localparam logic [31:0] DG_UNDEF = 32'h0000_2014;
  localparam logic [31:0] DG_OPERATED = 32'h0000_8004;
  localparam logic [31:0] DG_ERR_TIME = 32'h0000_F002;
  localparam logic [31:0] DG_ERR_AFTER_EN = 32'h0000_F00F;
  localparam logic [31:0] DG_ERR_AFTER_PANIC = 32'h0000_F010;

  typedef enum logic [1:0] {POS_REL, POS_OPER, POS_PANIC, POS_UNDEF} pos_t;
  typedef enum logic [2:0] {ST_WAIT_REL, ST_ARMED, ST_ON, ST_PANIC, ST_ERROR} state_t;

endpackage : foot_pkg

/* sync2.sv */
`timescale 1ns/100ps
module sync2 #(
  parameter int WIDTH = 6
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // Two flops, first one read only by the second
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule : sync2

/* safety_foot_switch_monitor.sv */
// Contract
// [RQ1] Enable only after all channels were seen in the released position.
// [RQ2] No enable while safety activation is low.
// [RQ3] Released to operated under permitted conditions closes the enable.
// [RQ4] Panic position opens the enable at once.
// [RQ5] After panic the enable stays open until released, even through operated.
// [RQ6] Return from operated to released opens the enable.
// [RQ7] Two-channel mode uses inputs 1-2, four-channel mode inputs 1-4.
// [RQ8] Wire break or lost activation is an error, cleared at released position; the code flags it only from ST_ON, and ST_ARMED returns to ST_WAIT_REL.
// [RQ9] Exceeding the enable time limit is an error, cleared at released position.
// [RQ10] Time limit elapsing opens the enable and raises the error together.
// [RQ11] Error output is high while an error is present, low otherwise.
// [RQ12] Optional block enable input deactivates the function; no enable then.
// [RQ13] Limit off or 0.5 to 10.0 min in 0.5 min steps; actual time output.
// [RQ14] Limit off keeps the enable closed while operated pattern holds.
// [RQ15] Diagnostic word carries fixed status codes for each state.
// [RQ16] Setting picks two or four channels and block enable required or not.
// [RQ17] Enable timer starts at enable, counts ticks, clears at withdrawal.
// [RQ18] Any undefined contact pattern keeps or forces the enable open.
//
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
module safety_foot_switch_monitor #(
  parameter int unsigned TICK_CYCLES = foot_pkg::TICK_CYCLES_DEF
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic pedal_channel_in_1,
  input wire logic pedal_channel_in_2,
  input wire logic pedal_channel_in_3,
  input wire logic pedal_channel_in_4,
  input wire logic safety_activation_in,
  input wire logic block_enable_in,
  output logic enable_out,
  output logic error_out,
  output logic [15:0] enable_time_actual,
  output logic [31:0] diagnostic_word,
  output logic irq,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  // ****************************************
  // Functions
  // ****************************************
  // Contact pattern to pedal position
  function automatic foot_pkg::pos_t decode_pos(input logic four, input logic [3:0] c);
    foot_pkg::pos_t p;
    p = foot_pkg::POS_UNDEF;
    if (four) begin
      if (c == foot_pkg::PAT4_REL) p = foot_pkg::POS_REL;
      else if (c == foot_pkg::PAT4_OPER) p = foot_pkg::POS_OPER;
      else if (c == foot_pkg::PAT4_PANIC) p = foot_pkg::POS_PANIC;
    end else begin
      if (c[1:0] == foot_pkg::PAT2_REL) p = foot_pkg::POS_REL;
      else if (c[1:0] == foot_pkg::PAT2_OPER) p = foot_pkg::POS_OPER;
      else if (c[1:0] == foot_pkg::PAT2_PANIC) p = foot_pkg::POS_PANIC;
    end
    return p;
  endfunction : decode_pos

  // Register address is mapped
  function automatic logic is_mapped(input logic [7:0] a);
    return (a == foot_pkg::OFF_CTRL) || (a == foot_pkg::OFF_STATUS) || (a == foot_pkg::OFF_DIAG) ||
           (a == foot_pkg::OFF_IRQ_STAT) || (a == foot_pkg::OFF_IRQ_MASK);
  endfunction : is_mapped

  // ****************************************
  // Input synchronisation
  // ****************************************
  logic [5:0] pins_sync;
  logic [3:0] ch;
  logic sa, blk;

  sync2 #(.WIDTH(6)) u_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .async_in({block_enable_in, safety_activation_in, pedal_channel_in_4, pedal_channel_in_3,
               pedal_channel_in_2, pedal_channel_in_1}),
    .sync_out(pins_sync)
  );

  assign ch = pins_sync[3:0];
  assign sa = pins_sync[4];
  assign blk = pins_sync[5];

  // ****************************************
  // Configuration and decode
  // ****************************************
  logic four_ch, ext_req, block_ok, active, timeout, err_timeout, next_err_timeout;
  logic [4:0] limit, lim_eff;
  logic [15:0] limit_units;
  foot_pkg::pos_t pos;
  foot_pkg::state_t state, next_state;

  // Position, activation and limit decode
  assign pos = decode_pos(four_ch, ch); // RQ7
  assign block_ok = !ext_req || blk; // RQ12 RQ16
  assign active = block_ok && sa; // RQ2
  assign lim_eff = (limit > foot_pkg::LIMIT_MAX) ? foot_pkg::LIMIT_MAX : limit; // RQ13
  assign limit_units = 16'({11'h000, lim_eff} * foot_pkg::STEP_UNITS); // RQ13
  assign timeout = (lim_eff != 5'h00) && (enable_time_actual >= limit_units); // RQ9 RQ14

  // ****************************************
  // Sequence state machine
  // ****************************************
  // Next state, in ST_ON panic first, then release, then faults
  always_comb begin
    next_state = state;
    next_err_timeout = err_timeout;
    if (!block_ok) begin
      // An error outlives deactivation and still needs the released pedal
      if (state != foot_pkg::ST_ERROR || pos == foot_pkg::POS_REL) next_state = foot_pkg::ST_WAIT_REL; // RQ8 RQ12
    end else begin
      unique case (state)
        foot_pkg::ST_WAIT_REL: begin
          if (sa && pos == foot_pkg::POS_REL) next_state = foot_pkg::ST_ARMED; // RQ1
        end
        foot_pkg::ST_ARMED: begin
          if (!sa || pos == foot_pkg::POS_UNDEF) next_state = foot_pkg::ST_WAIT_REL; // RQ2 RQ18
          else if (pos == foot_pkg::POS_OPER) next_state = foot_pkg::ST_ON; // RQ3
          else if (pos == foot_pkg::POS_PANIC) next_state = foot_pkg::ST_PANIC;
        end
        foot_pkg::ST_ON: begin
          if (pos == foot_pkg::POS_PANIC) begin
            next_state = foot_pkg::ST_PANIC; // RQ4
          end else if (pos == foot_pkg::POS_REL) begin
            next_state = foot_pkg::ST_WAIT_REL; // RQ6
          end else if (pos == foot_pkg::POS_UNDEF || !sa) begin
            next_state = foot_pkg::ST_ERROR; // RQ8 RQ18
            next_err_timeout = 1'b0;
          end else if (timeout) begin
            next_state = foot_pkg::ST_ERROR; // RQ10
            next_err_timeout = 1'b1;
          end
        end
        foot_pkg::ST_PANIC: begin
          if (pos == foot_pkg::POS_REL) next_state = foot_pkg::ST_WAIT_REL; // RQ5
        end
        foot_pkg::ST_ERROR: begin
          if (pos == foot_pkg::POS_REL) next_state = foot_pkg::ST_WAIT_REL; // RQ8 RQ9
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state <= foot_pkg::ST_WAIT_REL;
      err_timeout <= 1'b0;
    end else begin
      state <= next_state;
      err_timeout <= next_err_timeout;
    end
  end

  // Outputs straight from the state flops
  assign enable_out = (state == foot_pkg::ST_ON); // RQ3 RQ14
  assign error_out = (state == foot_pkg::ST_ERROR); // RQ11

  // ****************************************
  // Enable timer
  // ****************************************
  logic [31:0] pre;
  logic tick;

  assign tick = (pre == 32'(TICK_CYCLES - 1));

  // Prescaler and saturating actual time, cleared outside enable
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pre <= '0;
      enable_time_actual <= '0;
    end else if (!enable_out) begin
      pre <= '0; // RQ17
      enable_time_actual <= '0; // RQ17
    end else begin
      pre <= tick ? '0 : pre + 32'h0000_0001;
      if (tick && enable_time_actual != foot_pkg::ACTUAL_MAX) begin
        enable_time_actual <= enable_time_actual + 16'h0001; // RQ17
      end
    end
  end

  // ****************************************
  // Diagnostics
  // ****************************************
  logic [31:0] next_diag;

  // Status code from block state and pedal position
  always_comb begin
    next_diag = foot_pkg::DG_UNDEF;
    if (!block_ok) next_diag = foot_pkg::DG_NO_ENABLE; // RQ15
    else if (state == foot_pkg::ST_ERROR) next_diag = err_timeout ? foot_pkg::DG_ERR_TIME : foot_pkg::DG_ERR_AFTER_EN;
    else if (state == foot_pkg::ST_PANIC && pos == foot_pkg::POS_OPER) next_diag = foot_pkg::DG_ERR_AFTER_PANIC;
    else if (state == foot_pkg::ST_ON) next_diag = foot_pkg::DG_OPERATED;
    else if (!sa) next_diag = foot_pkg::DG_WAIT_ACT;
    else if (pos == foot_pkg::POS_REL) next_diag = foot_pkg::DG_RELEASED;
    else if (pos == foot_pkg::POS_PANIC || state == foot_pkg::ST_PANIC) next_diag = foot_pkg::DG_PANIC;
  end

  // Diagnostic word register
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) diagnostic_word <= foot_pkg::DG_NO_ENABLE;
    else diagnostic_word <= next_diag; // RQ15
  end

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  localparam int IRQ_W_T = foot_pkg::IRQ_W;
  logic aw_held, w_held, do_write, ar_take;
  logic [7:0] waddr;
  logic [3:0] sbuf;
  logic [IRQ_W_T-1:0] irq_stat, irq_mask, events, rd_clear;
  logic [31:0] wbuf, ctrl_word, stat_word, rd_word;

  // Channel readiness and transfer strobes
  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  assign arready = !rvalid;
  assign do_write = aw_held && w_held && !bvalid;
  assign ar_take = arvalid && arready;

  // Write address and data captured in either order
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      waddr <= '0;
      wbuf <= '0;
      sbuf <= '0;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        waddr <= awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        wbuf <= wdata;
        sbuf <= wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response and register writes with byte lanes
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      bvalid <= 1'b0;
      bresp <= foot_pkg::RESP_OKAY;
      four_ch <= foot_pkg::CTRL_FOUR_RST; // RQ16
      ext_req <= foot_pkg::CTRL_EXT_RST; // RQ16
      limit <= foot_pkg::CTRL_LIM_RST; // RQ13
      irq_mask <= '0;
    end else begin
      if (do_write) begin
        bvalid <= 1'b1;
        bresp <= is_mapped(waddr) ? foot_pkg::RESP_OKAY : foot_pkg::RESP_SLVERR;
        if (waddr == foot_pkg::OFF_CTRL && sbuf[0]) begin
          four_ch <= wbuf[foot_pkg::CTRL_FOUR_BIT];
          ext_req <= wbuf[foot_pkg::CTRL_EXT_BIT];
        end
        if (waddr == foot_pkg::OFF_CTRL && sbuf[1]) limit <= wbuf[foot_pkg::CTRL_LIM_LSB +: foot_pkg::LIM_W];
        if (waddr == foot_pkg::OFF_IRQ_MASK && sbuf[0]) irq_mask <= wbuf[IRQ_W_T-1:0];
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Readback words
  always_comb begin
    ctrl_word = '0;
    ctrl_word[foot_pkg::CTRL_FOUR_BIT] = four_ch;
    ctrl_word[foot_pkg::CTRL_EXT_BIT] = ext_req;
    ctrl_word[foot_pkg::CTRL_LIM_LSB +: foot_pkg::LIM_W] = limit;
    stat_word = '0;
    stat_word[foot_pkg::STAT_EN_BIT] = enable_out;
    stat_word[foot_pkg::STAT_ERR_BIT] = error_out;
    stat_word[foot_pkg::STAT_ACT_LSB +: 16] = enable_time_actual;
  end

  // Read selection
  assign rd_word = (araddr == foot_pkg::OFF_CTRL) ? ctrl_word :
                   (araddr == foot_pkg::OFF_STATUS) ? stat_word :
                   (araddr == foot_pkg::OFF_DIAG) ? diagnostic_word :
                   (araddr == foot_pkg::OFF_IRQ_STAT) ? {{(32-IRQ_W_T){1'b0}}, irq_stat} :
                   (araddr == foot_pkg::OFF_IRQ_MASK) ? {{(32-IRQ_W_T){1'b0}}, irq_mask} : '0;

  // Read data channel
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= foot_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rvalid <= 1'b1;
      rdata <= rd_word;
      rresp <= is_mapped(araddr) ? foot_pkg::RESP_OKAY : foot_pkg::RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  // Events from state changes, cleared by a read of the interrupt status register
  assign events[foot_pkg::IRQ_GRANT] = (next_state == foot_pkg::ST_ON) && (state != foot_pkg::ST_ON);
  assign events[foot_pkg::IRQ_WITHDRAW] = (state == foot_pkg::ST_ON) && (next_state != foot_pkg::ST_ON);
  assign events[foot_pkg::IRQ_ERROR] = (next_state == foot_pkg::ST_ERROR) && (state != foot_pkg::ST_ERROR);
  assign events[foot_pkg::IRQ_PANIC] = (next_state == foot_pkg::ST_PANIC) && (state != foot_pkg::ST_PANIC);
  assign rd_clear = (ar_take && araddr == foot_pkg::OFF_IRQ_STAT) ? '1 : '0;
  assign irq = |(irq_stat & irq_mask);

  // Sticky status, set wins over clear
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) irq_stat <= '0;
    else irq_stat <= (irq_stat & ~rd_clear) | events;
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  a_grant_after_release: assert property ($rose(enable_out) |-> $past(state == foot_pkg::ST_ARMED) // RQ1 RQ3
    && $past(pos == foot_pkg::POS_OPER)) else $error("enable without prior release");
  a_activation_gate: assert property ($rose(enable_out) |-> $past(active)) else $error("enable without activation"); // RQ2
  a_panic_drop: assert property (pos == foot_pkg::POS_PANIC |=> !enable_out) else $error("panic kept enable"); // RQ4
  a_panic_hold: assert property (state == foot_pkg::ST_PANIC && pos != foot_pkg::POS_REL |=> !enable_out [*2]) // RQ5
    else $error("enable after panic");
  a_release_drop: assert property (enable_out && pos == foot_pkg::POS_REL |=> !enable_out && !error_out) // RQ6
    else $error("release kept enable");
  a_undef_error: assert property (enable_out && block_ok && pos == foot_pkg::POS_UNDEF // RQ8 RQ18
    |=> error_out && !enable_out) else $error("undefined pattern not flagged");
  // The diagnostic word trails the state by one cycle
  a_timeout_error: assert property (enable_out && block_ok && sa && pos == foot_pkg::POS_OPER && timeout // RQ9 RQ10
    |=> error_out && !enable_out ##1 (!$past(block_ok) || diagnostic_word == foot_pkg::DG_ERR_TIME))
    else $error("timeout missed");
  a_error_ack: assert property (error_out && pos != foot_pkg::POS_REL |=> error_out) // RQ8 RQ9 RQ11
    else $error("error cleared early");
  a_block_off: assert property (!block_ok |=> !enable_out && diagnostic_word == foot_pkg::DG_NO_ENABLE) // RQ12
    else $error("inactive block enabled");
  a_timer_clear: assert property (!enable_out |=> enable_time_actual == 16'h0000) else $error("timer not cleared"); // RQ17
  a_no_limit_hold: assert property (lim_eff == 5'h00 && enable_out && block_ok && sa // RQ14
    && pos == foot_pkg::POS_OPER |=> enable_out) else $error("enable dropped without limit");
  a_irq_error_bit: assert property ($rose(error_out) |-> irq_stat[foot_pkg::IRQ_ERROR]) // RQ11
    else $error("error event not latched");

  c_grant: cover property ($rose(enable_out));
  c_timeout: cover property (enable_out ##1 error_out && err_timeout);
  c_panic: cover property (enable_out ##1 state == foot_pkg::ST_PANIC);
  c_release: cover property (enable_out ##1 state == foot_pkg::ST_WAIT_REL);

endmodule : safety_foot_switch_monitor

/* pedal_model.sv */
`timescale 1ns/100ps
// ****************************************
// Foot switch contacts for a commanded pedal position
// ****************************************
module pedal_model (
  input wire foot_pkg::pos_t pos,
  input wire logic four,
  input wire logic [1:0] spare,
  output logic [3:0] ch
);
  logic [3:0] p4;
  logic [1:0] p2;
  // Contact pattern of each position, a broken one when undefined
  assign p4 = (pos == foot_pkg::POS_REL) ? foot_pkg::PAT4_REL :
              (pos == foot_pkg::POS_OPER) ? foot_pkg::PAT4_OPER :
              (pos == foot_pkg::POS_PANIC) ? foot_pkg::PAT4_PANIC : 4'h7;
  assign p2 = (pos == foot_pkg::POS_REL) ? foot_pkg::PAT2_REL :
              (pos == foot_pkg::POS_OPER) ? foot_pkg::PAT2_OPER :
              (pos == foot_pkg::POS_PANIC) ? foot_pkg::PAT2_PANIC : 2'h0;
  // A two-channel switch leaves contacts 3 and 4 unwired, so they wander
  assign ch = four ? p4 : {spare, p2};
endmodule : pedal_model

/* tb.sv */
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; $display("ERROR %0t mismatch", $time); end end
module tb;
  localparam foot_pkg::pos_t REL = foot_pkg::POS_REL;
  localparam foot_pkg::pos_t OPR = foot_pkg::POS_OPER;
  localparam foot_pkg::pos_t PAN = foot_pkg::POS_PANIC;
  localparam foot_pkg::pos_t UND = foot_pkg::POS_UNDEF;
  logic ref_clk, nrst, sa, blk, four, irq, enable_out, error_out;
  foot_pkg::pos_t pos;
  logic [1:0] spare, bresp, rresp;
  logic [3:0] ch, wstrb;
  logic [15:0] enable_time_actual;
  logic [31:0] diagnostic_word, wdata, rdata;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [33:0] expq[$];
  int err_total, comparisons;
  integer seed;

  pedal_model pm (.pos, .four, .spare, .ch);
  safety_foot_switch_monitor #(.TICK_CYCLES(4)) dut (.ref_clk, .nrst, .pedal_channel_in_1(ch[0]),
    .pedal_channel_in_2(ch[1]), .pedal_channel_in_3(ch[2]), .pedal_channel_in_4(ch[3]),
    .safety_activation_in(sa), .block_enable_in(blk), .enable_out, .error_out, .enable_time_actual,
    .diagnostic_word, .irq, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);

  // ****************************************
  // Clock and result watcher
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Takes the oldest note whenever a bus answer is handed over
  always @(posedge ref_clk) begin
    if (rvalid && rready) `CHK({rresp, rdata}, expq.pop_front())
    if (bvalid && bready) `CHK({bresp, 32'h0}, expq.pop_front())
  end

  // ****************************************
  // Tasks
  // ****************************************
  task close_out;
    $display("err_total %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    expq.push_back({r, 32'h0});
    while (!bvalid && n < 200) begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    @(posedge ref_clk);
    if (n >= 200) begin
      err_total++;
      close_out();
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = foot_pkg::RESP_OKAY);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    expq.push_back({r, d});
    while (!rvalid && n < 200) begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    @(posedge ref_clk);
    if (n >= 200) begin
      err_total++;
      close_out();
    end
  endtask : rd

  // Moves the pedal and lets syncs, state and diagnostics settle
  task automatic go(input foot_pkg::pos_t p, input logic s);
    pos <= p;
    sa <= s;
    spare <= 2'($random(seed));
    repeat (8) @(posedge ref_clk);
  endtask : go

  task automatic ck(input logic e, input logic r);
    `CHK(enable_out, e)
    `CHK(error_out, r)
  endtask : ck

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    seed = 32'h7E501911;
    {nrst, sa, blk, four, spare, awvalid, wvalid, bready, arvalid, rready} = '0;
    four = 1'b1;
    pos = REL;
    wstrb = 4'hF;
    {awaddr, araddr, wdata} = '0;
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    rd(foot_pkg::OFF_CTRL, 32'h1);
    rd(foot_pkg::OFF_IRQ_MASK, 32'h0);
    rd(8'h14, 32'h0, foot_pkg::RESP_SLVERR);
    wr(8'h14, 32'h1, foot_pkg::RESP_SLVERR);
    wr(foot_pkg::OFF_IRQ_MASK, 32'hF, foot_pkg::RESP_OKAY);
    go(OPR, 1'b0);
    ck(1'b0, 1'b0);
    rd(foot_pkg::OFF_DIAG, foot_pkg::DG_WAIT_ACT);
    go(OPR, 1'b1);
    ck(1'b0, 1'b0);
    go(REL, 1'b1);
    rd(foot_pkg::OFF_DIAG, foot_pkg::DG_RELEASED);
    go(OPR, 1'b1);
    ck(1'b1, 1'b0);
    rd(foot_pkg::OFF_DIAG, foot_pkg::DG_OPERATED);
    `CHK(irq, 1'b1)
    rd(foot_pkg::OFF_IRQ_STAT, 32'h1);
    `CHK(irq, 1'b0)
    repeat (1500) @(posedge ref_clk);
    ck(1'b1, 1'b0);
    go(REL, 1'b1);
    ck(1'b0, 1'b0);
    rd(foot_pkg::OFF_STATUS, 32'h0);
    rd(foot_pkg::OFF_IRQ_STAT, 32'h2);
    wr(foot_pkg::OFF_IRQ_MASK, 32'h8, foot_pkg::RESP_OKAY);
    go(OPR, 1'b1);
    `CHK(irq, 1'b0)
    go(PAN, 1'b1);
    ck(1'b0, 1'b0);
    `CHK(irq, 1'b1)
    rd(foot_pkg::OFF_DIAG, foot_pkg::DG_PANIC);
    go(OPR, 1'b1);
    ck(1'b0, 1'b0);
    rd(foot_pkg::OFF_DIAG, foot_pkg::DG_ERR_AFTER_PANIC);
    wr(foot_pkg::OFF_IRQ_MASK, 32'h0, foot_pkg::RESP_OKAY);
    `CHK(irq, 1'b0)
    go(REL, 1'b1);
    go(OPR, 1'b1);
    ck(1'b1, 1'b0);
    go(UND, 1'b1);
    ck(1'b0, 1'b1);
    rd(foot_pkg::OFF_DIAG, foot_pkg::DG_ERR_AFTER_EN);
    go(REL, 1'b1);
    ck(1'b0, 1'b0);
    go(OPR, 1'b1);
    go(OPR, 1'b0);
    ck(1'b0, 1'b1);
    go(REL, 1'b1);
    ck(1'b0, 1'b0);
    four <= 1'b0;
    wr(foot_pkg::OFF_CTRL, 32'h100, foot_pkg::RESP_OKAY);
    go(REL, 1'b1);
    go(OPR, 1'b1);
    ck(1'b1, 1'b0);
    repeat (600) @(posedge ref_clk);
    `CHK(enable_time_actual != 16'h0, 1'b1)
    repeat (700) @(posedge ref_clk);
    ck(1'b0, 1'b1);
    rd(foot_pkg::OFF_STATUS, 32'h2);
    rd(foot_pkg::OFF_DIAG, foot_pkg::DG_ERR_TIME);
    go(REL, 1'b1);
    ck(1'b0, 1'b0);
    four <= 1'b1;
    wr(foot_pkg::OFF_CTRL, 32'h3, foot_pkg::RESP_OKAY);
    go(REL, 1'b1);
    go(OPR, 1'b1);
    ck(1'b0, 1'b0);
    rd(foot_pkg::OFF_DIAG, foot_pkg::DG_NO_ENABLE);
    blk <= 1'b1;
    go(REL, 1'b1);
    go(OPR, 1'b1);
    ck(1'b1, 1'b0);
    blk <= 1'b0;
    go(OPR, 1'b1);
    ck(1'b0, 1'b0);
    blk <= 1'b1;
    go(REL, 1'b1);
    go(OPR, 1'b1);
    go(UND, 1'b1);
    blk <= 1'b0;
    go(UND, 1'b1);
    ck(1'b0, 1'b1);
    go(REL, 1'b1);
    ck(1'b0, 1'b0);
    close_out();
  end
endmodule : tb
